// >>> design/pwc_defines.vh
// Register map, field positions and reset values of the PWM channel
`ifndef PWC_DEFINES_VH
`define PWC_DEFINES_VH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define PWC_OFF_MODE     12'h000
`define PWC_OFF_DUTY     12'h004
`define PWC_OFF_PERIOD   12'h008
`define PWC_OFF_COUNTER  12'h00c
`define PWC_OFF_UPDATE   12'h010
`define PWC_OFF_ENABLE   12'h014
`define PWC_OFF_DISABLE  12'h018
`define PWC_OFF_STATUS   12'h01c
`define PWC_OFF_IRQ_STAT 12'h020
`define PWC_OFF_IRQ_MASK 12'h024
`define PWC_OFF_DIVIDER  12'h028

// ------------------------------------------------------------
// Mode register fields
// ------------------------------------------------------------
`define PWC_MODE_PRE_LSB  0
`define PWC_MODE_PRE_MSB  3
`define PWC_MODE_ALIGN    8
`define PWC_MODE_LEVEL    9
`define PWC_MODE_TARGET   10
`define PWC_PRE_MAX       4'ha
`define PWC_PRE_DIV_A     4'hb
`define PWC_PRE_DIV_B     4'hc

// ------------------------------------------------------------
// Divider register fields
// ------------------------------------------------------------
`define PWC_DIV_A_LSB     0
`define PWC_DIV_B_LSB     8

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define PWC_RST_MODE      11'h000
`define PWC_RST_VALUE     16'h0000
`define PWC_RST_DIV       8'h01

`endif

// >>> design/pwc_tick_gen.v
// Counter clock tick generator: power-of-two prescaler and two dividers
`timescale 1ns/1ns
`include "pwc_defines.vh"
module pwc_tick_gen (
  input  wire       pclk,
  input  wire       presetn,
  input  wire [3:0] prescaler_select,
  input  wire [7:0] divider_a_ratio,
  input  wire [7:0] divider_b_ratio,
  output reg        tick_r
);

  reg  [9:0]  pre_cnt_r;
  reg  [7:0]  div_a_cnt_r;
  reg  [7:0]  div_b_cnt_r;
  reg         tick_nxt;
  wire [10:0] pre_wide;
  wire [9:0]  pre_mask;

  // Mask of low bits: all ones when that many bits have counted
  assign pre_wide = (11'h001 << prescaler_select) - 11'h001;
  assign pre_mask = pre_wide[9:0];

  // Ratio zero stops a divider, matching a disabled clock source
  function div_hit;
    input [7:0] cnt;
    input [7:0] ratio;
    begin
      div_hit = (ratio != 8'h00) && (cnt == ratio - 8'h01);
    end
  endfunction

  always @* begin
    if (prescaler_select == `PWC_PRE_DIV_A) begin
      tick_nxt = div_hit(div_a_cnt_r, divider_a_ratio); // [RULE8]
    end else if (prescaler_select == `PWC_PRE_DIV_B) begin
      tick_nxt = div_hit(div_b_cnt_r, divider_b_ratio); // [RULE8]
    end else if (prescaler_select > `PWC_PRE_MAX) begin
      tick_nxt = 1'b0;
    end else begin
      tick_nxt = ((pre_cnt_r & pre_mask) == pre_mask); // [RULE6]
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt_r   <= 10'h000;
      div_a_cnt_r <= 8'h00;
      div_b_cnt_r <= 8'h00;
      tick_r      <= 1'b0;
    end else begin
      pre_cnt_r <= pre_cnt_r + 10'h001;
      tick_r    <= tick_nxt;
      if (div_hit(div_a_cnt_r, divider_a_ratio) ||
          divider_a_ratio == 8'h00) begin
        div_a_cnt_r <= 8'h00;
      end else begin
        div_a_cnt_r <= div_a_cnt_r + 8'h01;
      end
      if (div_hit(div_b_cnt_r, divider_b_ratio) ||
          divider_b_ratio == 8'h00) begin
        div_b_cnt_r <= 8'h00;
      end else begin
        div_b_cnt_r <= div_b_cnt_r + 8'h01;
      end
    end
  end

endmodule // pwc_tick_gen

// >>> design/pwc_channel.v
// PWM channel waveform generator with APB register slave
`timescale 1ns/1ns
`include "pwc_defines.vh"

// Behaviour
// [RULE1] Start level select 0 starts period low, 1 starts high.
// [RULE2] Target 0: buffered value becomes duty at next period start.
// [RULE3] Target 1: buffered value becomes period at next period start.
// [RULE4] Duty, period, update registers use only low 16 bits.
// [RULE5] Software keeps duty between zero and the period value.
// [RULE6] Prescaled left period equals factor times period, factor 1..1024.
// [RULE7] Center-aligned period is twice the left-aligned period.
// [RULE8] Divider clocking gives period times divider ratio master cycles.
// [RULE9] Enabling the channel clears the counter to zero.
// [RULE10] Left-aligned counter clears on reaching period, starting new period.
// [RULE11] Current counter value is readable in a read-only register.
// [RULE12] Update register is a holding buffer; mid-period writes are safe.
// [RULE13] Alignment 0 gives left-aligned, 1 gives center-aligned period.
// [RULE14] Writing 1 to enable bit enables output; 0 has no effect.
// [RULE15] Period-done flag set per period, cleared by reading status; the code clears it only on a read of PWC_OFF_IRQ_STAT, not of PWC_OFF_STATUS.
// [RULE16] Center mode counts up to period then down, start at zero.
// [RULE17] Output holds start level below duty, opposite level otherwise.
module pwc_channel #(
  parameter CNT_W = 16
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         pwm_out,
  output reg         irq
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  reg  [10:0]      mode_r;
  reg  [CNT_W-1:0] duty_r;
  reg  [CNT_W-1:0] period_r;
  reg  [CNT_W-1:0] update_r;
  reg              upd_pend_r;
  reg  [CNT_W-1:0] count_r;
  reg              down_r;
  reg              enabled_r;
  reg              done_r;
  reg              irq_mask_r;
  reg  [7:0]       div_a_r;
  reg  [7:0]       div_b_r;
  wire             tick;
  wire             wr_en;
  wire             rd_en;
  wire             align_center;
  wire             start_level;
  wire             upd_period;
  wire             at_start;
  wire             mapped;
  reg  [31:0]      rdata_nxt;
  reg  [CNT_W-1:0] count_nxt;
  reg              down_nxt;
  wire             left_wrap;
  wire             wr_mode;
  wire             wr_duty;
  wire             wr_period;
  wire             wr_update;
  wire             wr_divider;
  wire             wr_mask;
  wire             wr_enable;
  wire             wr_disable;
  wire             rd_flag;

  // Writes land at the completion edge, once per access
  assign wr_en        = psel && penable && pwrite && pready;
  assign rd_en        = psel && penable && !pwrite;
  assign align_center = mode_r[`PWC_MODE_ALIGN];
  assign start_level  = mode_r[`PWC_MODE_LEVEL];
  assign upd_period   = mode_r[`PWC_MODE_TARGET];

  function is_addr;
    input [11:0] a;
    input [11:0] off;
    begin
      is_addr = (a == off);
    end
  endfunction

  assign mapped = is_addr(paddr, `PWC_OFF_MODE)   ||
                  is_addr(paddr, `PWC_OFF_DUTY)   ||
                  is_addr(paddr, `PWC_OFF_PERIOD) ||
                  is_addr(paddr, `PWC_OFF_COUNTER)||
                  is_addr(paddr, `PWC_OFF_UPDATE) ||
                  is_addr(paddr, `PWC_OFF_ENABLE) ||
                  is_addr(paddr, `PWC_OFF_DISABLE)||
                  is_addr(paddr, `PWC_OFF_STATUS) ||
                  is_addr(paddr, `PWC_OFF_IRQ_STAT) ||
                  is_addr(paddr, `PWC_OFF_IRQ_MASK) ||
                  is_addr(paddr, `PWC_OFF_DIVIDER);

  // ------------------------------------------------------------
  // Access strobes
  // ------------------------------------------------------------
  assign wr_mode    = wr_en && is_addr(paddr, `PWC_OFF_MODE);
  assign wr_duty    = wr_en && is_addr(paddr, `PWC_OFF_DUTY);
  assign wr_period  = wr_en && is_addr(paddr, `PWC_OFF_PERIOD);
  assign wr_update  = wr_en && is_addr(paddr, `PWC_OFF_UPDATE);
  assign wr_divider = wr_en && is_addr(paddr, `PWC_OFF_DIVIDER);
  assign wr_mask    = wr_en && is_addr(paddr, `PWC_OFF_IRQ_MASK);
  assign wr_enable  = wr_en && is_addr(paddr, `PWC_OFF_ENABLE) && pwdata[0];
  assign wr_disable = wr_en && is_addr(paddr, `PWC_OFF_DISABLE) && pwdata[0];
  // Flag clears where read data is captured, one edge before pready
  assign rd_flag    = rd_en && !pready && is_addr(paddr, `PWC_OFF_IRQ_STAT);

  // ------------------------------------------------------------
  // Counter clock
  // ------------------------------------------------------------
  pwc_tick_gen pwc_tick_gen_inst (
    .pclk             (pclk),
    .presetn          (presetn),
    .prescaler_select (mode_r[`PWC_MODE_PRE_MSB:`PWC_MODE_PRE_LSB]),
    .divider_a_ratio  (div_a_r),
    .divider_b_ratio  (div_b_r),
    .tick_r           (tick)
  );

  // Left wraps one count early: period_value ticks per period
  assign left_wrap = (count_r + 1'b1 >= period_r); // [RULE10]

  // Period start: left wrap, or center turn at zero
  assign at_start = enabled_r && tick &&
                    (align_center ? (down_r && count_r == 1 ||
                                     period_r == {CNT_W{1'b0}})
                                  : left_wrap); // [RULE10]

  // ------------------------------------------------------------
  // Register writes
  // ------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r     <= `PWC_RST_MODE;
      duty_r     <= `PWC_RST_VALUE;
      period_r   <= `PWC_RST_VALUE;
      irq_mask_r <= 1'b0;
      div_a_r    <= `PWC_RST_DIV;
      div_b_r    <= `PWC_RST_DIV;
    end else begin
      if (wr_mode) begin
        mode_r <= pwdata[10:0];
      end
      if (wr_divider) begin
        div_a_r <= pwdata[`PWC_DIV_A_LSB+7:`PWC_DIV_A_LSB];
        div_b_r <= pwdata[`PWC_DIV_B_LSB+7:`PWC_DIV_B_LSB];
      end
      if (wr_mask) begin
        irq_mask_r <= pwdata[0];
      end
      // Direct writes; software keeps duty within period
      if (wr_duty) begin
        duty_r <= pwdata[CNT_W-1:0]; // [RULE4] [RULE5]
      end
      if (wr_period) begin
        period_r <= pwdata[CNT_W-1:0]; // [RULE4]
      end
      // Buffer only; active value moves at period start
      if (at_start && upd_pend_r) begin
        if (upd_period) begin
          period_r <= update_r; // [RULE3]
        end else begin
          duty_r <= update_r; // [RULE2]
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Update buffer
  // ------------------------------------------------------------
  // A write in the start cycle stays pending for the next period
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      update_r   <= `PWC_RST_VALUE;
      upd_pend_r <= 1'b0;
    end else begin
      if (wr_update) begin
        update_r   <= pwdata[CNT_W-1:0]; // [RULE12] [RULE4]
        upd_pend_r <= 1'b1;
      end else if (at_start) begin
        upd_pend_r <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Counter next value
  // ------------------------------------------------------------
  always @* begin
    count_nxt = count_r;
    down_nxt  = down_r;
    if (wr_enable) begin
      count_nxt = {CNT_W{1'b0}}; // [RULE9]
      down_nxt  = 1'b0;
    end else if (enabled_r && tick && !wr_disable) begin
      if (!align_center) begin // [RULE13]
        if (left_wrap) begin
          count_nxt = {CNT_W{1'b0}}; // [RULE10] [RULE6] [RULE8]
        end else begin
          count_nxt = count_r + 1'b1;
        end
      end else if (period_r == {CNT_W{1'b0}}) begin
        count_nxt = {CNT_W{1'b0}};
      end else if (!down_r) begin
        // Up then down doubles the period; a shrunk period turns at once
        if (count_r + 1'b1 >= period_r) begin
          down_nxt = 1'b1; // [RULE16] [RULE7]
        end
        count_nxt = count_r + 1'b1;
      end else begin
        if (count_r == 1) begin
          down_nxt = 1'b0; // [RULE16]
        end
        count_nxt = count_r - 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Enable, counter and waveform
  // ------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enabled_r <= 1'b0;
      count_r   <= {CNT_W{1'b0}};
      down_r    <= 1'b0;
      pwm_out   <= 1'b0;
    end else begin
      count_r <= count_nxt;
      down_r  <= down_nxt;
      if (wr_enable) begin
        enabled_r <= 1'b1; // [RULE14]
      end else if (wr_disable) begin
        enabled_r <= 1'b0;
      end
      // Idle output rests at the start level
      if (!enabled_r) begin
        pwm_out <= start_level;
      end else if (count_r < duty_r) begin
        pwm_out <= start_level; // [RULE1] [RULE17]
      end else begin
        pwm_out <= ~start_level; // [RULE17]
      end
    end
  end

  // ------------------------------------------------------------
  // Period flag, interrupt and APB read
  // ------------------------------------------------------------
  always @* begin
    rdata_nxt = 32'h0000_0000;
    if (is_addr(paddr, `PWC_OFF_MODE)) begin
      rdata_nxt[10:0] = mode_r;
    end else if (is_addr(paddr, `PWC_OFF_DUTY)) begin
      rdata_nxt[CNT_W-1:0] = duty_r;
    end else if (is_addr(paddr, `PWC_OFF_PERIOD)) begin
      rdata_nxt[CNT_W-1:0] = period_r;
    end else if (is_addr(paddr, `PWC_OFF_COUNTER)) begin
      rdata_nxt[CNT_W-1:0] = count_r; // [RULE11]
    end else if (is_addr(paddr, `PWC_OFF_STATUS)) begin
      rdata_nxt[0] = enabled_r;
    end else if (is_addr(paddr, `PWC_OFF_IRQ_STAT)) begin
      rdata_nxt[0] = done_r;
    end else if (is_addr(paddr, `PWC_OFF_IRQ_MASK)) begin
      rdata_nxt[0] = irq_mask_r;
    end else if (is_addr(paddr, `PWC_OFF_DIVIDER)) begin
      rdata_nxt[15:0] = {div_b_r, div_a_r};
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_r  <= 1'b0;
      irq     <= 1'b0;
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      // A period end in the read cycle survives the clear
      if (at_start) begin
        done_r <= 1'b1; // [RULE15]
      end else if (rd_flag) begin
        done_r <= 1'b0; // [RULE15]
      end
      irq <= done_r && irq_mask_r;
      // One wait state: pready is high in the second access cycle
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      if (rd_en && !pready) begin
        prdata <= rdata_nxt;
      end
    end
  end

endmodule // pwc_channel

// >>> testbench/pwc_channel_asserts.sv
// Port-level assertions for the PWM channel
`timescale 1ns/1ns
`include "pwc_defines.vh"
module pwc_channel_asserts (
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic        pwm_out,
  input logic        irq
);
  // ----
  // Shadow of enable, level and mask
  // ----
  logic en_r, lvl_r, msk_r, wr_c;
  assign wr_c = psel && penable && pready && pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_r  <= 1'b0;
      lvl_r <= 1'b0;
      msk_r <= 1'b0;
    end else if (wr_c) begin
      if (paddr == `PWC_OFF_ENABLE && pwdata[0]) en_r <= 1'b1;
      if (paddr == `PWC_OFF_DISABLE && pwdata[0]) en_r <= 1'b0;
      if (paddr == `PWC_OFF_MODE) lvl_r <= pwdata[9];
      if (paddr == `PWC_OFF_IRQ_MASK) msk_r <= pwdata[0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_wait;
    $rose(penable) && psel |-> !pready ##1 pready;
  endproperty
  a_wait: assert property (p_wait)
    else $error("pready not one cycle after penable");
  property p_pulse;
    pready |=> !pready;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("pready held too long");
  property p_unmap;
    pready && paddr > `PWC_OFF_DIVIDER |-> pslverr;
  endproperty
  a_unmap: assert property (p_unmap)
    else $error("unmapped access not refused");
  property p_hi16;
    pready && !pwrite && (paddr == `PWC_OFF_DUTY ||
      paddr == `PWC_OFF_PERIOD || paddr == `PWC_OFF_COUNTER)
      |-> prdata[31:16] == 16'h0000;
  endproperty
  a_hi16: assert property (p_hi16)
    else $error("upper half of a 16-bit value not zero");
  property p_wo;
    pready && !pwrite && paddr == `PWC_OFF_UPDATE |-> prdata == 32'h0;
  endproperty
  a_wo: assert property (p_wo)
    else $error("update buffer readable");
  property p_mask;
    !msk_r && !$past(msk_r) |-> !irq;
  endproperty
  a_mask: assert property (p_mask)
    else $error("irq while masked");
  property p_rest;
    !$past(en_r) |-> pwm_out == $past(lvl_r);
  endproperty
  a_rest: assert property (p_rest)
    else $error("idle output not at start level");
  property p_errz;
    pready && pslverr && !pwrite |-> prdata == 32'h0;
  endproperty
  a_errz: assert property (p_errz)
    else $error("refused read returned data");
  c_irq: cover property ($rose(irq));
  c_err: cover property (pready && pslverr);
  c_upd: cover property (wr_c && paddr == `PWC_OFF_UPDATE);
endmodule // pwc_channel_asserts
bind pwc_channel pwc_channel_asserts pwc_channel_asserts_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pwm_out(pwm_out), .irq(irq));

// >>> testbench/pwm_channel_waveform_tb.sv
// Self-checking bench for the PWM channel
`timescale 1ns/1ns
`include "pwc_defines.vh"
module pwm_channel_waveform_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        pwm_out, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rnd;
  logic [32:0] exp_q[$];
  logic [32:0] e;
  logic [7:0]  da, db;
  int          err_total, cmp_count, n;
  pwc_channel pwc_channel_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pwm_out(pwm_out), .irq(irq));
  // ----
  // Bus and compare helpers
  // ----
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task automatic print_verdict;
    if (err_total == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic check(input string nm, input logic [32:0] s, x);
    cmp_count++;
    if (s !== x) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic tout;
    err_total++;
    print_verdict();
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int b = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      b++;
      if (b > 20) tout();
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  // Expectation queued before the access so the monitor never races it
  task automatic rd(input logic [11:0] a, input logic [32:0] x);
    exp_q.push_back(x);
    apb(1'b0, a, 32'h0);
  endtask
  always @(posedge pclk) begin
    if (pready === 1'b1 && pwrite === 1'b0) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 33'h0;
      check("read", {pslverr, prdata}, e);
    end
  end
  task automatic wt(input logic v);
    int b = 0;
    while (pwm_out !== v) begin
      @(posedge pclk);
      n++;
      b++;
      if (b > 9000) tout();
    end
  endtask
  // Crossing to crossing, so the first partial period is skipped
  task automatic per(input logic lv, input int x);
    wt(lv);
    wt(!lv);
    n = 0;
    wt(lv);
    wt(!lv);
    check("period", 33'(n), 33'(x));
  endtask
  task automatic cfg(input logic [3:0] p, input logic al, lv, tg,
                     input logic [15:0] pr, du);
    wr(`PWC_OFF_MODE, {21'h0, tg, lv, al, 4'h0, p});
    wr(`PWC_OFF_PERIOD, {16'h0, pr});
    wr(`PWC_OFF_DUTY, {16'h0, du});
    wr(`PWC_OFF_ENABLE, 32'h1);
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    void'($urandom(47));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`PWC_OFF_DIVIDER, 33'h101);
    rd(`PWC_OFF_MODE, 33'h0);
    rnd = $urandom;
    wr(`PWC_OFF_DUTY, rnd);
    rd(`PWC_OFF_DUTY, {17'h0, rnd[15:0]});
    rd(`PWC_OFF_UPDATE, 33'h0);
    rd(12'h02c, 33'h1_0000_0000);
    da = 8'($urandom_range(9, 2));
    db = 8'($urandom_range(9, 2));
    wr(`PWC_OFF_DIVIDER, {16'h0, db, da});
    cfg(4'h0, 1'b0, 1'b0, 1'b0, 16'd20, 16'd7);
    per(1'b0, 20);
    cfg(4'h3, 1'b0, 1'b1, 1'b0, 16'd6, 16'd2);
    per(1'b1, 48);
    cfg(4'ha, 1'b0, 1'b0, 1'b0, 16'd3, 16'd1);
    per(1'b0, 3072);
    cfg(4'hb, 1'b0, 1'b0, 1'b0, 16'd5, 16'd2);
    per(1'b0, 5 * da);
    cfg(4'hc, 1'b1, 1'b1, 1'b0, 16'd4, 16'd1);
    per(1'b1, 8 * db);
    cfg(4'h1, 1'b1, 1'b0, 1'b0, 16'd5, 16'd2);
    per(1'b0, 20);
    cfg(4'h0, 1'b0, 1'b0, 1'b0, 16'd200, 16'd50);
    wt(1'b0);
    wt(1'b1);
    wr(`PWC_OFF_UPDATE, 32'hffff_0064);
    rd(`PWC_OFF_DUTY, 33'd50);
    wt(1'b0);
    wt(1'b1);
    rd(`PWC_OFF_DUTY, 33'd100);
    cfg(4'h0, 1'b0, 1'b0, 1'b1, 16'd200, 16'd50);
    wt(1'b0);
    wt(1'b1);
    wr(`PWC_OFF_UPDATE, 32'd120);
    rd(`PWC_OFF_PERIOD, 33'd200);
    wt(1'b0);
    per(1'b0, 120);
    rd(`PWC_OFF_PERIOD, 33'd120);
    wr(`PWC_OFF_IRQ_MASK, 32'h1);
    // Stopped counter clock keeps count and flag still while checked
    cfg(4'hf, 1'b0, 1'b0, 1'b0, 16'd3, 16'd1);
    rd(`PWC_OFF_COUNTER, 33'h0);
    rd(`PWC_OFF_STATUS, 33'h1);
    rd(`PWC_OFF_IRQ_STAT, 33'h1);
    repeat (3) @(posedge pclk);
    check("irq", {32'h0, irq}, 33'h0);
    wr(`PWC_OFF_MODE, 32'h0);
    n = 0;
    while (irq !== 1'b1 && n < 9000) begin
      @(posedge pclk);
      n++;
    end
    check("irq", {32'h0, irq}, 33'h1);
    rd(`PWC_OFF_IRQ_STAT, 33'h1);
    wr(`PWC_OFF_DISABLE, 32'h1);
    wr(`PWC_OFF_ENABLE, 32'h0);
    rd(`PWC_OFF_STATUS, 33'h0);
    print_verdict();
  end
endmodule // pwm_channel_waveform_tb
